//--- hw/tb_irq_ctrl.sv
// Implementation choices: the placing of the registers and strobed register access.
`timescale 1ns/10ps
module tb_irq_ctrl
  import tbirq_pkg::*;
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              resetn,
  // register port
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  // tick clock enable
  input  wire logic              tick_dedicated_clock,
  // event sources
  input  wire logic              serial_module_done,
  input  wire logic              periph_irq_pin_n,
  input  wire logic              second_serial_done,
  input  wire logic              low_supply_detect,
  input  wire logic [5:0]        async_serial_events,
  input  wire logic [TMR_N-1:0]  timer_match,
  // core sequencer
  input  wire logic              stack_full,
  input  wire logic              irq_ack,
  input  wire logic              reti_done,
  output logic                   irq_req,
  output logic      [2:0]        irq_vector,
  output logic                   wake_req,
  // oscillator control
  output logic                   slow_crystal_low_power
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0]       tbc_ff;
  logic [7:0]       vec_en_ff;
  logic [7:0]       nxt_vec_en;
  logic [NUM_VEC-1:0] vec_flag_ff;
  logic [NUM_VEC-1:0] nxt_vec_flag;
  logic [SRC_N-1:0] src_en_ff;
  logic [SRC_N-1:0] src_flag_ff;
  logic [SRC_N-1:0] nxt_src_flag;
  logic [TMR_N-1:0] tmr_en_ff;
  logic [TMR_N-1:0] tmr_flag_ff;
  logic [TMR_N-1:0] nxt_tmr_flag;
  logic             pin_prev_ff;
  logic             lowv_prev_ff;
  logic             irq_req_ff;
  logic [2:0]       irq_vector_ff;
  logic             wake_ff;
  logic [7:0]       rdata_ff;

  logic             ack_ok;
  logic [NUM_VEC-1:0] ack_clr;
  logic [SRC_N-1:0] src_set;
  logic [11:0]      all_src_ff;
  logic [11:0]      all_src_nxt;
  logic [11:0]      src_rise;
  logic [11:0]      src_live;
  logic [NUM_VEC-1:0] vec_set;
  logic [NUM_VEC-1:0] vec_ok;
  logic [NUM_VEC-1:0] pending;
  logic [7:0]       rd_mux;

  tick_if tb ();

  // lowest set index of the pending vectors
  function automatic logic [2:0] first_set(input logic [NUM_VEC-1:0] v);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = NUM_VEC - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = 3'(i);
      end
    end
    return idx;
  endfunction

  // write strobe decode
  function automatic logic wr_hit(input logic [ADDR_W-1:0] ofs);
    return reg_wr && (reg_addr == ofs);
  endfunction

  // ----------------------------------------------------------------
  // time base generators
  // ----------------------------------------------------------------
  assign tb.on      = tbc_ff[TBC_ON_BIT];
  assign tb.clk_sel = tbc_ff[TBC_CLK_BIT];
  assign tb.p1_sel  = tbc_ff[TBC_P1_LSB +: 2];
  assign tb.p0_sel  = tbc_ff[TBC_P0_LSB +: 3];

  tick_gen #(
    .DIV_WIDTH (DIV_W)
  ) u_tick_gen (
    .clk                  (clk),
    .resetn               (resetn),
    .tick_dedicated_clock (tick_dedicated_clock),
    .tb                   (tb.gen)
  );

  // ----------------------------------------------------------------
  // plain configuration registers
  // ----------------------------------------------------------------
  // time base control, source and timer enables
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tbc_ff    <= TBC_RESET;
      src_en_ff <= '0;
      tmr_en_ff <= '0;
    end else begin
      if (wr_hit(OFS_TBC)) begin
        tbc_ff <= reg_wdata;
      end
      if (wr_hit(OFS_SRC_EN)) begin
        src_en_ff <= reg_wdata[SRC_N-1:0];
      end
      if (wr_hit(OFS_TMR_EN)) begin
        tmr_en_ff <= reg_wdata[TMR_N-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // source request flags
  // ----------------------------------------------------------------
  // edge detectors for the pin and the supply report
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pin_prev_ff  <= 1'b1;
      lowv_prev_ff <= 1'b0;
    end else begin
      pin_prev_ff  <= periph_irq_pin_n;
      lowv_prev_ff <= low_supply_detect;
    end
  end

  // hardware set events per source
  always_comb begin
    src_set             = '0;
    src_set[SRC_SERIAL] = serial_module_done;
    src_set[SRC_PIN]    = pin_prev_ff && !periph_irq_pin_n;
    src_set[SRC_SER2]   = second_serial_done;
    src_set[SRC_LOWV]   = low_supply_detect && !lowv_prev_ff;
    src_set[SRC_ASYNC]  = |async_serial_events;
  end

  // software write, then hardware set wins over a clear
  always_comb begin
    nxt_src_flag = wr_hit(OFS_SRC_FLAG) ? reg_wdata[SRC_N-1:0] : src_flag_ff;
    nxt_src_flag = nxt_src_flag | src_set;
    nxt_tmr_flag = wr_hit(OFS_TMR_FLAG) ? reg_wdata[TMR_N-1:0] : tmr_flag_ff;
    nxt_tmr_flag = nxt_tmr_flag | timer_match;
  end

  // source flags; never touched by servicing
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      src_flag_ff <= '0;
      tmr_flag_ff <= '0;
    end else begin
      src_flag_ff <= nxt_src_flag;
      tmr_flag_ff <= nxt_tmr_flag;
    end
  end

  // ----------------------------------------------------------------
  // vector flags and group membership
  // ----------------------------------------------------------------
  assign all_src_ff  = {tmr_flag_ff, src_flag_ff};
  assign all_src_nxt = {nxt_tmr_flag, nxt_src_flag};
  assign src_rise    = all_src_nxt & ~all_src_ff;
  assign src_live    = all_src_ff & {tmr_en_ff, src_en_ff};

  // group flags follow member rises; ticks set their own
  always_comb begin
    vec_set           = '0;
    vec_set[VEC_GRP0] = |(src_rise & GRP0_MASK);
    vec_set[VEC_GRP1] = |(src_rise & GRP1_MASK);
    vec_set[VEC_GRP2] = |(src_rise & GRP2_MASK);
    vec_set[VEC_GRP3] = |(src_rise & GRP3_MASK);
    vec_set[VEC_TB0]  = tb.tick0;
    vec_set[VEC_TB1]  = tb.tick1;
  end

  // a group calls only with an enabled member flag set
  always_comb begin
    vec_ok           = '1;
    vec_ok[VEC_GRP0] = |(src_live & GRP0_MASK);
    vec_ok[VEC_GRP1] = |(src_live & GRP1_MASK);
    vec_ok[VEC_GRP2] = |(src_live & GRP2_MASK);
    vec_ok[VEC_GRP3] = |(src_live & GRP3_MASK);
  end

  // acknowledge only of a request actually shown
  assign ack_ok  = irq_ack && irq_req_ff;
  assign ack_clr = ack_ok ? NUM_VEC'(1 << irq_vector_ff) : '0;

  // only the serviced vector flag is cleared; new sets win
  always_comb begin
    nxt_vec_flag = wr_hit(OFS_VEC_FLAG) ? reg_wdata[NUM_VEC-1:0] : vec_flag_ff;
    nxt_vec_flag = (nxt_vec_flag & ~ack_clr) | vec_set;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      vec_flag_ff <= '0;
    end else begin
      vec_flag_ff <= nxt_vec_flag;
    end
  end

  // ----------------------------------------------------------------
  // enables and global enable
  // ----------------------------------------------------------------
  // service clears global enable; return from interrupt sets it
  always_comb begin
    nxt_vec_en = wr_hit(OFS_VEC_EN) ? reg_wdata : vec_en_ff;
    nxt_vec_en[GIE_BIT] = reti_done || nxt_vec_en[GIE_BIT];
    if (ack_ok) begin
      nxt_vec_en[GIE_BIT] = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      vec_en_ff <= ZERO8;
    end else begin
      vec_en_ff <= nxt_vec_en;
    end
  end

  // ----------------------------------------------------------------
  // request to the core
  // ----------------------------------------------------------------
  assign pending = vec_flag_ff & vec_en_ff[NUM_VEC-1:0] & vec_ok;

  // held off by a full stack; lowest index wins
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irq_req_ff    <= 1'b0;
      irq_vector_ff <= 3'h0;
    end else begin
      irq_req_ff    <= (|pending) && vec_en_ff[GIE_BIT] && !stack_full && !ack_ok;
      irq_vector_ff <= first_set(pending);
    end
  end

  // wake-up on any flag rising, enables ignored
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wake_ff <= 1'b0;
    end else begin
      wake_ff <= (|src_rise) || (|(nxt_vec_flag & ~vec_flag_ff));
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  always_comb begin
    case (reg_addr)
      OFS_TBC:      rd_mux = tbc_ff;
      OFS_VEC_EN:   rd_mux = vec_en_ff;
      OFS_VEC_FLAG: rd_mux = {2'h0, vec_flag_ff};
      OFS_SRC_EN:   rd_mux = {3'h0, src_en_ff};
      OFS_SRC_FLAG: rd_mux = {3'h0, src_flag_ff};
      OFS_TMR_EN:   rd_mux = {1'b0, tmr_en_ff};
      OFS_TMR_FLAG: rd_mux = {1'b0, tmr_flag_ff};
      OFS_STATUS:   rd_mux = {3'h0, irq_vector_ff, stack_full, irq_req_ff};
      default:      rd_mux = ZERO8;
    endcase
  end

  // data stand only in the cycle after the strobe
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata_ff <= ZERO8;
    end else begin
      rdata_ff <= reg_rd ? rd_mux : ZERO8;
    end
  end

  assign reg_rdata              = rdata_ff;
  assign irq_req                = irq_req_ff;
  assign irq_vector             = irq_vector_ff;
  assign wake_req               = wake_ff;
  assign slow_crystal_low_power = tbc_ff[TBC_LP_BIT];

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_serviced;
    irq_ack && irq_req_ff;
  endsequence

  sequence s_pin_fall;
    pin_prev_ff && !periph_irq_pin_n;
  endsequence

  a_service_gie: assert property (
    s_serviced ##1 1 |-> !vec_en_ff[GIE_BIT]
      && (!vec_flag_ff[$past(irq_vector_ff)] || $past(vec_set[irq_vector_ff])))
    else $error("service did not clear global enable or vector flag");

  a_req_cause: assert property (
    irq_req_ff |-> $past(vec_en_ff[GIE_BIT] && !stack_full && (|pending)))
    else $error("request without enable or pending flag");

  a_stack_block: assert property (
    stack_full |=> !irq_req_ff)
    else $error("request raised while stack full");

  a_tick_flag: assert property (
    tb.tick0 |=> vec_flag_ff[VEC_TB0])
    else $error("tick did not set its flag");

  a_group_src: assert property (
    s_serviced and (!reg_wr) |=> (all_src_ff & $past(all_src_ff)) == $past(all_src_ff))
    else $error("service touched a source flag");

  a_wake_rise: assert property (
    (|src_rise) |=> wake_ff)
    else $error("flag rise gave no wake-up");

  a_reti_gie: assert property (
    reti_done && !ack_ok |=> vec_en_ff[GIE_BIT])
    else $error("return did not set global enable");

  a_pin_edge: assert property (
    s_pin_fall |=> src_flag_ff[SRC_PIN] ##1 src_flag_ff[SRC_PIN] || $past(reg_wr))
    else $error("pin fall did not set its flag");

  a_group_set: assert property (
    (|(src_rise & GRP2_MASK)) |=> vec_flag_ff[VEC_GRP2])
    else $error("group flag not set by member");

  a_flag_hold: assert property (
    src_flag_ff[SRC_SERIAL] && !reg_wr |=> src_flag_ff[SRC_SERIAL])
    else $error("flag dropped without a clear");

endmodule

//--- hw/tbirq_pkg.sv
package tbirq_pkg;

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;

  localparam logic [2:0] OFS_TBC      = 3'h0;
  localparam logic [2:0] OFS_VEC_EN   = 3'h1;
  localparam logic [2:0] OFS_VEC_FLAG = 3'h2;
  localparam logic [2:0] OFS_SRC_EN   = 3'h3;
  localparam logic [2:0] OFS_SRC_FLAG = 3'h4;
  localparam logic [2:0] OFS_TMR_EN   = 3'h5;
  localparam logic [2:0] OFS_TMR_FLAG = 3'h6;
  localparam logic [2:0] OFS_STATUS   = 3'h7;

  // ----------------------------------------------------------------
  // time base control fields
  // ----------------------------------------------------------------
  localparam logic [7:0] TBC_RESET    = 8'h37;
  localparam int         TBC_ON_BIT   = 7;
  localparam int         TBC_CLK_BIT  = 6;
  localparam int         TBC_P1_LSB   = 4;
  localparam int         TBC_LP_BIT   = 3;
  localparam int         TBC_P0_LSB   = 0;
  localparam int         TICK0_LOG2   = 8;
  localparam int         TICK1_LOG2   = 12;
  localparam int         DIV_W        = 15;
  localparam logic [1:0] SYS_DIV_LAST = 2'h3;

  // ----------------------------------------------------------------
  // vectors, lower index wins; vector flag and enable bits follow it
  // ----------------------------------------------------------------
  localparam int         NUM_VEC  = 6;
  localparam logic [2:0] VEC_GRP0 = 3'h0;
  localparam logic [2:0] VEC_GRP1 = 3'h1;
  localparam logic [2:0] VEC_TB0  = 3'h2;
  localparam logic [2:0] VEC_TB1  = 3'h3;
  localparam logic [2:0] VEC_GRP2 = 3'h4;
  localparam logic [2:0] VEC_GRP3 = 3'h5;
  localparam int         GIE_BIT  = 7;
  localparam logic [7:0] ZERO8    = 8'h00;

  // ----------------------------------------------------------------
  // grouped sources: {timer[6:0], src[4:0]}
  // ----------------------------------------------------------------
  localparam int          SRC_N      = 5;
  localparam int          TMR_N      = 7;
  localparam int          SRC_SERIAL = 0;
  localparam int          SRC_PIN    = 1;
  localparam int          SRC_SER2   = 2;
  localparam int          SRC_LOWV   = 3;
  localparam int          SRC_ASYNC  = 4;
  localparam logic [11:0] GRP0_MASK  = 12'h01E0;
  localparam logic [11:0] GRP1_MASK  = 12'h0E00;
  localparam logic [11:0] GRP2_MASK  = 12'h0013;
  localparam logic [11:0] GRP3_MASK  = 12'h000C;

endpackage

//--- hw/tick_gen.sv
`timescale 1ns/10ps
module tick_gen
  import tbirq_pkg::*;
#(
  parameter int DIV_WIDTH = DIV_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // dedicated tick clock, one-cycle enable
  input wire logic tick_dedicated_clock,
  // control and ticks
  tick_if.gen      tb
);

  if (DIV_WIDTH < TICK1_LOG2 + 3) begin : g_bad_width
    $error("tick_gen: divider too narrow for longest period");
  end

  logic [1:0]           sys_div_ff;
  logic [DIV_WIDTH-1:0] cnt_ff;
  logic                 tick0_ff;
  logic                 tick1_ff;
  logic                 tick_en;
  logic [DIV_WIDTH-1:0] mask0;
  logic [DIV_WIDTH-1:0] mask1;

  // all ones in the low log2 bits of the divider
  function automatic logic [DIV_WIDTH-1:0] period_mask(input int log2);
    logic [DIV_WIDTH:0] one;
    one = {{DIV_WIDTH{1'b0}}, 1'b1};
    return DIV_WIDTH'((one << log2) - 1'b1);
  endfunction

  // ----------------------------------------------------------------
  // input clock select
  // ----------------------------------------------------------------
  // system clock divided by four
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sys_div_ff <= 2'h0;
    end else begin
      sys_div_ff <= sys_div_ff + 2'h1;
    end
  end

  assign tick_en = tb.clk_sel ? (sys_div_ff == SYS_DIV_LAST) : tick_dedicated_clock;
  assign mask0   = period_mask(TICK0_LOG2 + int'(tb.p0_sel));
  assign mask1   = period_mask(TICK1_LOG2 + int'(tb.p1_sel));

  // ----------------------------------------------------------------
  // divider chain and overflow ticks
  // ----------------------------------------------------------------
  // chain held clear while the generators are off
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_ff <= '0;
    end else if (!tb.on) begin
      cnt_ff <= '0;
    end else if (tick_en) begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end

  // one-cycle tick at the end of each selected period
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tick0_ff <= 1'b0;
      tick1_ff <= 1'b0;
    end else begin
      tick0_ff <= tb.on && tick_en && ((cnt_ff & mask0) == mask0);
      tick1_ff <= tb.on && tick_en && ((cnt_ff & mask1) == mask1);
    end
  end

  assign tb.tick0 = tick0_ff;
  assign tb.tick1 = tick1_ff;

  a_ticks_off: assert property (@(posedge clk) disable iff (!resetn)
    !tb.on |=> !tick0_ff && !tick1_ff)
    else $error("tick while generators disabled");

endmodule

//--- hw/tick_if.sv
`timescale 1ns/10ps
// control from the register side, ticks back from the dividers
interface tick_if;
  logic       on;
  logic       clk_sel;
  logic [2:0] p0_sel;
  logic [1:0] p1_sel;
  logic       tick0;
  logic       tick1;
  modport ctrl (output on, clk_sel, p0_sel, p1_sel, input tick0, tick1);
  modport gen  (input on, clk_sel, p0_sel, p1_sel, output tick0, tick1);
endinterface

//--- tb/core_model.sv
`timescale 1ns/10ps
module core_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // request from the block
  input  wire logic       irq_req,
  input  wire logic [2:0] irq_vector,
  // behaviour knobs
  input  wire logic [1:0] lat,
  input  wire logic       reti_en,
  // answers and record
  output logic            irq_ack,
  output logic            reti_done,
  output logic      [2:0] last_vec,
  output int              taken
);
  logic [1:0] wait_ff;
  logic [2:0] ret_ff;

  // take a request after lat idle cycles
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irq_ack <= 1'h0;
      wait_ff <= 2'h0;
    end else if (irq_req && !irq_ack && wait_ff == lat) begin
      irq_ack <= 1'h1;
      wait_ff <= 2'h0;
    end else begin
      irq_ack <= 1'h0;
      wait_ff <= (irq_req && !irq_ack) ? wait_ff + 2'h1 : 2'h0;
    end
  end

  // record the vector, return from the routine four cycles later
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      last_vec  <= 3'h0;
      taken     <= 0;
      ret_ff    <= 3'h0;
      reti_done <= 1'h0;
    end else begin
      reti_done <= reti_en && ret_ff == 3'h4;
      if (irq_ack && irq_req) begin
        last_vec <= irq_vector;
        taken    <= taken + 1;
        ret_ff   <= 3'h1;
      end else if (ret_ff != 3'h0) begin
        ret_ff <= (ret_ff == 3'h4) ? 3'h0 : ret_ff + 3'h1;
      end
    end
  end
endmodule

//--- tb/tb_irq_ctrl_test.sv
`timescale 1ns/10ps
module tb_irq_ctrl_test
  import tbirq_pkg::*;
;
  logic              clk, resetn, reg_wr, reg_rd, tick_clk, ser_done, pin_n, ser2_done, lowv;
  logic              stack_full, reti_en, irq_ack, reti_done, irq_req, wake_req, lowpow;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata;
  logic [5:0]        async_ev;
  logic [TMR_N-1:0]  tmr;
  logic [1:0]        lat;
  logic [2:0]        irq_vector, last_vec;
  int                taken, err_total, compares, cyc, wakes, n, w;
  int                last_t[8], per[8];

  tb_irq_ctrl DUT (.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tick_dedicated_clock(tick_clk),
    .serial_module_done(ser_done), .periph_irq_pin_n(pin_n), .second_serial_done(ser2_done),
    .low_supply_detect(lowv), .async_serial_events(async_ev), .timer_match(tmr),
    .stack_full(stack_full), .irq_ack(irq_ack), .reti_done(reti_done), .irq_req(irq_req),
    .irq_vector(irq_vector), .wake_req(wake_req), .slow_crystal_low_power(lowpow));
  core_model core (.clk(clk), .resetn(resetn), .irq_req(irq_req), .irq_vector(irq_vector),
    .lat(lat), .reti_en(reti_en), .irq_ack(irq_ack), .reti_done(reti_done),
    .last_vec(last_vec), .taken(taken));

  // clock
  initial begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end

  // tick clock every other cycle, wake count, spacing of acks per vector
  always @(posedge clk) begin
    tick_clk <= resetn ? ~tick_clk : 1'h0;
    cyc <= cyc + 1;
    if (wake_req === 1'h1) wakes <= wakes + 1;
    if (irq_ack && irq_req) begin
      per[irq_vector] <= cyc - last_t[irq_vector];
      last_t[irq_vector] <= cyc;
    end
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr    <= 1'h1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'h0;
  endtask

  task automatic rd_chk(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_rd   <= 1'h1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'h0;
    #1 chk(reg_rdata, e);
  endtask

  task automatic wait_ack(input int n0);
    for (int i = 0; i < 200 && taken == n0; i++) @(posedge clk);
  endtask

  function automatic logic [2:0] grp_of(input int i);
    logic [11:0] b;
    b = 12'h001 << i;
    if ((b & GRP0_MASK) != 0) return VEC_GRP0;
    if ((b & GRP1_MASK) != 0) return VEC_GRP1;
    if ((b & GRP2_MASK) != 0) return VEC_GRP2;
    return VEC_GRP3;
  endfunction

  // one event from grouped source i, {timer, src} order
  task automatic fire(input int i);
    @(posedge clk);
    case (i)
      SRC_SERIAL: ser_done <= 1'h1;
      SRC_PIN:    pin_n <= 1'h0;
      SRC_SER2:   ser2_done <= 1'h1;
      SRC_LOWV:   lowv <= 1'h1;
      SRC_ASYNC:  async_ev <= 6'h01 << $urandom_range(5);
      default:    tmr <= 7'h01 << (i - SRC_N);
    endcase
    @(posedge clk);
    ser_done  <= 1'h0;
    pin_n     <= 1'h1;
    ser2_done <= 1'h0;
    lowv      <= 1'h0;
    async_ev  <= 6'h00;
    tmr       <= 7'h00;
  endtask

  task automatic close_out;
    $display("errors %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'hc21d_dd60));
    {reg_wr, reg_rd, ser_done, ser2_done, lowv, stack_full, reti_en} = 7'h00;
    pin_n = 1'h1;
    {reg_addr, reg_wdata, async_ev, tmr, lat} = '0;
    resetn = 1'h0;
    repeat (2) @(posedge clk);
    resetn <= 1'h1;
    rd_chk(OFS_TBC, TBC_RESET);
    for (int a = 1; a < 8; a++) rd_chk(3'(a), ZERO8);
    chk(lowpow, 0);
    wr(OFS_TBC, 8'h08);
    @(posedge clk);
    chk(lowpow, 1);
    wr(OFS_VEC_FLAG, 8'h0C);
    repeat (2) @(posedge clk);
    chk(wakes != 0, 1);
    n = taken;
    wr(OFS_VEC_EN, 8'h0C);
    repeat (5) @(posedge clk);
    chk(taken, n);
    stack_full <= 1'h1;
    wr(OFS_VEC_EN, 8'h8C);
    repeat (10) @(posedge clk);
    chk(taken, n);
    reti_en    <= 1'h1;
    lat        <= 2'($urandom_range(3));
    stack_full <= 1'h0;
    wait_ack(n);
    chk(last_vec, VEC_TB0);
    wait_ack(n + 1);
    chk(last_vec, VEC_TB1);
    repeat (8) @(posedge clk);
    rd_chk(OFS_VEC_FLAG, ZERO8);
    wr(OFS_TBC, 8'h82);
    repeat (33000) @(posedge clk);
    chk(per[VEC_TB0], 2048);
    chk(per[VEC_TB1], 8192);
    wr(OFS_TBC, 8'hC0);
    repeat (5200) @(posedge clk);
    chk(per[VEC_TB0], 1024);
    wr(OFS_TBC, 8'h40);
    repeat (20) @(posedge clk);
    n = taken;
    repeat (2100) @(posedge clk);
    chk(taken, n);
    reti_en <= 1'h0;
    wr(OFS_VEC_FLAG, ZERO8);
    for (int i = 0; i < SRC_N + TMR_N; i++) begin
      lat <= 2'($urandom_range(3));
      wr(OFS_SRC_EN, (i < SRC_N) ? 8'h01 << i : ZERO8);
      wr(OFS_TMR_EN, (i >= SRC_N) ? 8'h01 << (i - SRC_N) : ZERO8);
      wr(OFS_VEC_EN, 8'hB3);
      n = taken;
      w = wakes;
      fire(i);
      wait_ack(n);
      chk(last_vec, grp_of(i));
      chk(wakes != w, 1);
      repeat (2) @(posedge clk);
      rd_chk(OFS_VEC_EN, 8'h33);
      rd_chk(OFS_VEC_FLAG, ZERO8);
      rd_chk((i < SRC_N) ? OFS_SRC_FLAG : OFS_TMR_FLAG, 8'h01 << ((i < SRC_N) ? i : i - SRC_N));
      wr(OFS_SRC_FLAG, ZERO8);
      wr(OFS_TMR_FLAG, ZERO8);
    end
    close_out();
  end

  // watchdog: the sequence needs about 42000 cycles
  initial begin
    #1500000;
    err_total++;
    close_out();
  end
endmodule
